// [pkg/stage_pkg.sv]
// Shared constants and types for the power stage input reaction logic.
`default_nettype none

package stage_pkg;

  // Width of the dead-time and on-time counts.
  localparam int TIME_W = 12;

  // Sub-cycle phases: bit 1 is the side, bit 0 is set during the on-time.
  typedef enum logic [1:0] {
    PH_DT0 = 2'b00,
    PH_OT0 = 2'b01,
    PH_DT1 = 2'b10,
    PH_OT1 = 2'b11
  } phase_type;

  // Input reaction mode codes.
  localparam logic [3:0] MODE_NONE = 4'h0;
  localparam logic [3:0] MODE_STOP_WAIT = 4'h2;
  localparam logic [3:0] MODE_RUN_OPPOSITE = 4'h3;
  localparam logic [3:0] MODE_BLANK = 4'h4;
  localparam logic [3:0] MODE_HALT = 4'h7;
  localparam logic [3:0] MODE_EDGE = 4'h8;
  localparam logic [3:0] MODE_FIXED_EDGE = 4'h9;
  localparam logic [3:0] MODE_HOLD_OFF = 4'hE;

  // Reset values and the counter step.
  localparam logic [TIME_W-1:0] CNT_RESET = 12'h000;
  localparam logic [TIME_W-1:0] CNT_STEP = 12'h001;
  localparam phase_type PHASE_RESET = PH_DT0;
  localparam logic [1:0] PAIR_RESET = 2'b00;
  localparam logic SYNC_RESET = 1'b0;

endpackage

`default_nettype wire

// [rtl/reset_sync.sv]
// Reset release synchroniser: asserts at once, releases after two clock edges.
`default_nettype none

module reset_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  output logic rst_n_o
);

  typedef struct packed {
    logic first;
    logic second;
  } sync_type;

  sync_type s_r;
  sync_type s_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    s_nxt.first = 1'b1;
    s_nxt.second = s_r.first;
  end

  // Both stages clear at once when the reset pin goes low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r.first <= stage_pkg::SYNC_RESET;
      s_r.second <= stage_pkg::SYNC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rst_n_o = s_r.second;

endmodule

`default_nettype wire

// [rtl/input_sense.sv]
// Input sensing: synchronisers, polarity and edge detection for inputs A and B.
`default_nettype none

module input_sense (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [1:0] pin_i,
  input wire logic [1:0] input_active_polarity_i,
  output logic [1:0] active_o,
  output logic [1:0] edge_o
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic [1:0] prev;
  } sense_type;

  sense_type s_r;
  sense_type s_nxt;
  logic [1:0] level;

  // Polarity turns the synchronised pin into an active level and a start edge.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      assign level[g] = input_active_polarity_i[g] ? s_r.stable[g] : ~s_r.stable[g];
      assign edge_o[g] = level[g] & ~s_r.prev[g];
    end
  endgenerate

  assign active_o = level;

  // Two-stage synchroniser, then the previous active level for the edge.
  always_comb begin
    s_nxt.meta = pin_i;
    s_nxt.stable = s_r.meta;
    s_nxt.prev = level;
  end

  // State freezes while the clock enable is low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r.meta <= stage_pkg::PAIR_RESET;
      s_r.stable <= stage_pkg::PAIR_RESET;
      s_r.prev <= stage_pkg::PAIR_RESET;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// [rtl/stage_ctrl_input_fault_modes.sv]
// Input reaction logic of a two-output power stage generator with dead-times.
`default_nettype none

// Behaviour
// - Mode 2: input A is only looked at during dead-time zero and on-time zero.
// - Mode 2: A ends output zero, runs side one, then waits for A inactive.
// - Modes 2 and 3: a started side one sub-cycle always completes.
// - Mode 2: input B is only looked at during dead-time one and on-time one.
// - Mode 2: B ends output one, runs side zero, then waits for B inactive.
// - Modes 2 and 3: a started side zero sub-cycle always completes.
// - Mode 3: input A only acts during side zero phases.
// - Mode 3: A ends output zero, loops dead-one, on-one, dead-zero while active.
// - Mode 3: input B only acts during side one phases.
// - Mode 3: B ends output one, loops dead-zero, on-zero, dead-one while active.
// - Mode 4: an active input blanks both outputs, timing runs on.
// - Mode 7: a fault halts the generator until software sets run again.
// - Mode 7: either input halts during any phase.
// - Mode 8: an accepted edge cuts the current cycle short.
// - Modes 8 and 9: edges count only within the input's own on-time.
// - One-ramp edge retrigger on A restarts the ramp from zero.
// - Mode 9: an edge ends the output but keeps the cycle frequency.
// - Mode 14: edges leave the output frequency unchanged.
// - Mode 14: the input's output stays off while the input is active.
// - A 4-bit code selects the reaction; zero means no action.
// - Polarity bit set means rising edge or high level is active.
module stage_ctrl_input_fault_modes (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic input_a_i,
  input wire logic input_b_i,
  input wire logic [1:0] input_active_polarity_i,
  input wire logic [3:0] input_reaction_mode_a_i,
  input wire logic [3:0] input_reaction_mode_b_i,
  input wire logic generator_run_bit_i,
  input wire logic one_ramp_i,
  input wire logic [11:0] dead_time_zero_i,
  input wire logic [11:0] on_time_zero_i,
  input wire logic [11:0] dead_time_one_i,
  input wire logic [11:0] on_time_one_i,
  output logic stage_output_zero_o,
  output logic stage_output_one_o,
  output logic [1:0] phase_o,
  output logic halted_o
);

  typedef struct packed {
    stage_pkg::phase_type phase;
    logic [11:0] cnt;
    logic [1:0] seq;
    logic [1:0] stall;
    logic [1:0] cut;
    logic halted;
    logic run_prev;
    logic [1:0] out;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic rst_n;
  logic [1:0] act;
  logic [1:0] edg;
  logic [1:0][3:0] mode;
  logic [11:0] len;
  logic last;
  logic running;
  logic halt_hit;
  logic [1:0] kill;
  logic [1:0] cut_set;
  stage_pkg::phase_type ph_n;
  logic [11:0] cnt_n;

  // Dead-time phase of a side.
  function automatic stage_pkg::phase_type dead_of(input logic side);
    return stage_pkg::phase_type'({side, 1'b0});
  endfunction

  // On-time phase of a side.
  function automatic stage_pkg::phase_type on_of(input logic side);
    return stage_pkg::phase_type'({side, 1'b1});
  endfunction

  // Reset release is synchronised to the generator clock.
  reset_sync u_reset_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rst_n_o(rst_n)
  );

  // Inputs A and B pass two flip-flops before the polarity stage.
  input_sense u_input_sense (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .clk_en_i(clk_en_i),
    .pin_i({input_b_i, input_a_i}),
    .input_active_polarity_i(input_active_polarity_i),
    .active_o(act),
    .edge_o(edg)
  );

  // Input k belongs to side k: A to side zero, B to side one.
  assign mode[0] = input_reaction_mode_a_i;
  assign mode[1] = input_reaction_mode_b_i;

  // Length of the current phase; a zero length still lasts one cycle.
  always_comb begin
    case (s_r.phase)
      stage_pkg::PH_DT0: len = dead_time_zero_i;
      stage_pkg::PH_OT0: len = on_time_zero_i;
      stage_pkg::PH_DT1: len = dead_time_one_i;
      default: len = on_time_one_i;
    endcase
  end

  assign last = ({1'b0, s_r.cnt} + 13'h0001) >= {1'b0, len};
  assign running = generator_run_bit_i & ~s_r.halted;

  // Next state: halt, wait, fault sequences, retriggers and the outputs.
  always_comb begin
    s_nxt = s_r;
    s_nxt.run_prev = generator_run_bit_i;
    halt_hit = 1'b0;
    kill = 2'b00;
    cut_set = 2'b00;
    ph_n = s_r.phase;
    cnt_n = s_r.cnt;

    // Level reactions; codes not listed here fall through with no action.
    for (int k = 0; k < 2; k++) begin
      if (mode[k] == stage_pkg::MODE_HALT && act[k]) begin
        halt_hit = 1'b1;
      end
      if (mode[k] == stage_pkg::MODE_BLANK && act[k]) begin
        kill = 2'b11;
      end
      if (mode[k] == stage_pkg::MODE_HOLD_OFF && act[k]) begin
        kill[k] = 1'b1;
      end
    end

    // Only a fresh rising run bit lifts a halt.
    if (s_r.halted && generator_run_bit_i && !s_r.run_prev) begin
      s_nxt.halted = 1'b0;
    end

    if (running && halt_hit) begin
      s_nxt.halted = 1'b1;
    end else if (running && (|s_r.stall)) begin
      // Waiting after a mode 2 sequence; resume on the input's own dead-time.
      for (int k = 0; k < 2; k++) begin
        if (s_r.stall[k] && !act[k]) begin
          s_nxt.stall[k] = 1'b0;
          s_nxt.seq[k] = 1'b0;
          ph_n = dead_of(k == 1);
          cnt_n = stage_pkg::CNT_RESET;
        end
      end
    end else if (running) begin
      if (last) begin
        ph_n = stage_pkg::phase_type'(s_r.phase + 2'b01);
        cnt_n = stage_pkg::CNT_RESET;
      end else begin
        cnt_n = s_r.cnt + stage_pkg::CNT_STEP;
      end

      for (int k = 0; k < 2; k++) begin
        // End of the opposite on-time in a mode 2 sequence.
        if (s_r.seq[k] && last && s_r.phase == on_of(k == 0) &&
            mode[k] == stage_pkg::MODE_STOP_WAIT) begin
          if (act[k]) begin
            s_nxt.stall[k] = 1'b1;
            ph_n = s_r.phase;
            cnt_n = s_r.cnt;
          end else begin
            s_nxt.seq[k] = 1'b0;
          end
        end

        // End of the own dead-time in a mode 3 loop.
        if (s_r.seq[k] && last && s_r.phase == dead_of(k == 1) &&
            mode[k] == stage_pkg::MODE_RUN_OPPOSITE) begin
          if (act[k]) begin
            ph_n = dead_of(k == 0);
          end else begin
            s_nxt.seq[k] = 1'b0;
          end
        end

        // A fault on the input's own side starts the opposite sub-cycle.
        if (!s_r.seq[k] && s_r.phase[1] == (k == 1) && act[k] &&
            (mode[k] == stage_pkg::MODE_STOP_WAIT ||
             mode[k] == stage_pkg::MODE_RUN_OPPOSITE)) begin
          ph_n = dead_of(k == 0);
          cnt_n = stage_pkg::CNT_RESET;
          s_nxt.seq[k] = 1'b1;
        end

        // Edges count only inside the input's own on-time.
        if (edg[k] && s_r.phase == on_of(k == 1)) begin
          if (mode[k] == stage_pkg::MODE_EDGE) begin
            cnt_n = stage_pkg::CNT_RESET;
            if (k == 0 && one_ramp_i) begin
              ph_n = stage_pkg::PH_DT0;
            end else begin
              ph_n = dead_of(k == 0);
            end
          end
          if (mode[k] == stage_pkg::MODE_FIXED_EDGE) begin
            cut_set[k] = 1'b1;
          end
        end
      end
    end

    s_nxt.phase = ph_n;
    s_nxt.cnt = cnt_n;

    // A cut output stays off until its on-time ends; timing is untouched.
    for (int k = 0; k < 2; k++) begin
      s_nxt.cut[k] = (ph_n == s_r.phase) && (s_r.cut[k] || cut_set[k]);
    end

    // Outputs follow the next phase unless the run bit is low, or blanked, cut, waiting or halted.
    for (int k = 0; k < 2; k++) begin
      s_nxt.out[k] = generator_run_bit_i && !s_nxt.halted && !(|s_nxt.stall) &&
                     ph_n == on_of(k == 1) && !s_nxt.cut[k] && !kill[k];
    end
  end

  // All state freezes while the clock enable is low.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r.phase <= stage_pkg::PHASE_RESET;
      s_r.cnt <= stage_pkg::CNT_RESET;
      s_r.seq <= stage_pkg::PAIR_RESET;
      s_r.stall <= stage_pkg::PAIR_RESET;
      s_r.cut <= stage_pkg::PAIR_RESET;
      s_r.halted <= stage_pkg::SYNC_RESET;
      s_r.run_prev <= stage_pkg::SYNC_RESET;
      s_r.out <= stage_pkg::PAIR_RESET;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  assign stage_output_zero_o = s_r.out[0];
  assign stage_output_one_o = s_r.out[1];
  assign phase_o = s_r.phase;
  assign halted_o = s_r.halted;

  // A halted generator drives both outputs inactive.
  a_halt_outputs_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    s_r.halted |-> (s_r.out == 2'b00))
    else $error("outputs active while halted");

  // A mode 7 fault on either input halts the running generator.
  a_halt_entry_any: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && ((mode[0] == stage_pkg::MODE_HALT && act[0]) ||
                             (mode[1] == stage_pkg::MODE_HALT && act[1])))
    |=> (s_r.halted && !stage_output_zero_o && !stage_output_one_o))
    else $error("mode 7 fault did not halt");

  // A rising run bit releases a halt on the next edge.
  a_halt_release: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && s_r.halted && generator_run_bit_i && !s_r.run_prev) |=> !s_r.halted)
    else $error("run bit did not release halt");

  // A mode 2 fault on A jumps to dead-time one from zero.
  a_mode2_jump: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[0] == stage_pkg::MODE_STOP_WAIT &&
     mode[1] == stage_pkg::MODE_NONE && act[0] && !s_r.seq[0] &&
     !s_r.phase[1] && s_r.stall == 2'b00)
    |=> (s_r.phase == stage_pkg::PH_DT1 && s_r.cnt == 12'h000 && s_r.seq[0]))
    else $error("mode 2 fault did not jump to dead-time one");

  // A mode 2 fault on B jumps to dead-time zero from side one.
  a_mode2_jump_b: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[1] == stage_pkg::MODE_STOP_WAIT &&
     mode[0] == stage_pkg::MODE_NONE && act[1] && !s_r.seq[1] &&
     s_r.phase[1] && s_r.stall == 2'b00)
    |=> (s_r.phase == stage_pkg::PH_DT0 && s_r.cnt == 12'h000 && s_r.seq[1]))
    else $error("mode 2 fault on B did not jump to dead-time zero");

  // While waiting for an input to clear, both outputs are off.
  a_stall_outputs_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (s_r.stall != 2'b00) |-> (!stage_output_zero_o && !stage_output_one_o))
    else $error("output active while waiting");

  // A mode 3 loop skips on-time zero while input A stays active.
  a_mode3_loop: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[0] == stage_pkg::MODE_RUN_OPPOSITE &&
     mode[1] == stage_pkg::MODE_NONE && s_r.seq[0] && last && act[0] &&
     s_r.phase == stage_pkg::PH_DT0 && s_r.stall == 2'b00)
    |=> (s_r.phase == stage_pkg::PH_DT1 && !stage_output_zero_o))
    else $error("mode 3 loop did not skip on-time zero");

  // Mode 4 blanks both outputs one cycle after the input is active.
  a_mode4_blank: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && mode[0] == stage_pkg::MODE_BLANK && act[0])
    |=> (!stage_output_zero_o && !stage_output_one_o))
    else $error("mode 4 did not blank outputs");

  // Mode 14 holds output one off while input B is active.
  a_mode14_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && mode[1] == stage_pkg::MODE_HOLD_OFF && act[1]) |=> !stage_output_one_o)
    else $error("mode 14 did not hold output one off");

  // A mode 8 edge in on-time zero ends the cycle half at once.
  a_mode8_retrig: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[0] == stage_pkg::MODE_EDGE &&
     mode[1] == stage_pkg::MODE_NONE && edg[0] && !one_ramp_i &&
     s_r.phase == stage_pkg::PH_OT0 && s_r.stall == 2'b00)
    |=> (s_r.phase == stage_pkg::PH_DT1 && s_r.cnt == 12'h000))
    else $error("mode 8 edge did not cut the cycle");

  // In one-ramp mode a mode 8 edge on A restarts the ramp.
  a_one_ramp_restart: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[0] == stage_pkg::MODE_EDGE &&
     mode[1] == stage_pkg::MODE_NONE && edg[0] && one_ramp_i &&
     s_r.phase == stage_pkg::PH_OT0 && s_r.stall == 2'b00)
    |=> (s_r.phase == stage_pkg::PH_DT0 && s_r.cnt == 12'h000))
    else $error("one-ramp edge did not restart ramp");

  // A mode 9 edge cuts output zero but keeps the phase running.
  a_mode9_cut: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && running && mode[0] == stage_pkg::MODE_FIXED_EDGE &&
     mode[1] == stage_pkg::MODE_NONE && edg[0] && !last &&
     s_r.phase == stage_pkg::PH_OT0 && s_r.stall == 2'b00)
    |=> (!stage_output_zero_o && s_r.phase == stage_pkg::PH_OT0 &&
         s_r.cnt == $past(s_r.cnt) + 12'h001))
    else $error("mode 9 edge changed timing or left output on");

endmodule

`default_nettype wire

// [sim/fault_source.sv]
// Partner model: fault and retrigger sources that drive the two input pins.
`default_nettype none

module fault_source (
  input wire logic a_active_i,
  input wire logic b_active_i,
  input wire logic [1:0] input_active_polarity_i,
  output logic input_a_o,
  output logic input_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // An active source shows the polarity level, an idle one its inverse.
  assign input_a_o = ~(a_active_i ^ input_active_polarity_i[0]);
  assign input_b_o = ~(b_active_i ^ input_active_polarity_i[1]);
endmodule

`default_nettype wire

// [sim/testbench.sv]
// Self-checking testbench for the power stage input reaction logic.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk;
  logic rst_n;
  logic clk_en;
  logic run;
  logic one_ramp;
  logic a_act;
  logic b_act;
  logic [1:0] pol;
  logic [3:0] mode_a;
  logic [3:0] mode_b;
  logic [11:0] dt0;
  logic [11:0] ot0;
  logic [11:0] dt1;
  logic [11:0] ot1;
  logic pin_a;
  logic pin_b;
  logic out0;
  logic out1;
  logic halted;
  logic [1:0] phase;
  int errors;
  int cmp_count;

  stage_ctrl_input_fault_modes i_dut (
    .ref_clk_i(ref_clk),
    .rst_n_i(rst_n),
    .clk_en_i(clk_en),
    .input_a_i(pin_a),
    .input_b_i(pin_b),
    .input_active_polarity_i(pol),
    .input_reaction_mode_a_i(mode_a),
    .input_reaction_mode_b_i(mode_b),
    .generator_run_bit_i(run),
    .one_ramp_i(one_ramp),
    .dead_time_zero_i(dt0),
    .on_time_zero_i(ot0),
    .dead_time_one_i(dt1),
    .on_time_one_i(ot1),
    .stage_output_zero_o(out0),
    .stage_output_one_o(out1),
    .phase_o(phase),
    .halted_o(halted)
  );

  fault_source i_src (
    .a_active_i(a_act),
    .b_active_i(b_act),
    .input_active_polarity_i(pol),
    .input_a_o(pin_a),
    .input_b_o(pin_b)
  );

  // Free-running 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Compares one bit and counts the result.
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Compares the reported phase and counts the result.
  task automatic chk_phase(input logic [1:0] got, input stage_pkg::phase_type exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t phase: got %b expected %b", $time, got, exp);
    end
  endtask

  // Waits a bounded number of cycles for a phase, then checks it was reached.
  task automatic wait_phase(input stage_pkg::phase_type ph, input int limit);
    int n;
    n = 0;
    while (phase !== ph && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
    chk_phase(phase, ph);
  endtask

  // Returns to no reaction with both sources idle and lets the input path settle.
  task automatic idle();
    mode_a = stage_pkg::MODE_NONE;
    mode_b = stage_pkg::MODE_NONE;
    a_act = 1'b0;
    b_act = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  // Plain timing with no reaction: on-time zero lasts its full length.
  task automatic s_normal();
    int n;
    idle();
    wait_phase(stage_pkg::PH_DT1, 60);
    wait_phase(stage_pkg::PH_OT0, 60);
    n = 0;
    while (phase === stage_pkg::PH_OT0 && n < 40) begin
      chk_bit(out0, 1'b1, "out0 in on-time zero");
      @(negedge ref_clk);
      n++;
    end
    chk_bit(n == 20, 1'b1, "on-time zero length");
    wait_phase(stage_pkg::PH_OT1, 10);
    chk_bit(out1, 1'b1, "out1 in on-time one");
  endtask

  // Stop and wait on input A: ignored on side one, runs side one, then waits.
  task automatic s_mode2_a();
    int n;
    idle();
    mode_a = stage_pkg::MODE_STOP_WAIT;
    wait_phase(stage_pkg::PH_OT1, 60);
    a_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT1);
    chk_bit(out1, 1'b1, "out1 kept");
    a_act = 1'b0;
    wait_phase(stage_pkg::PH_OT0, 30);
    repeat (5) @(negedge ref_clk);
    a_act = 1'b1;
    wait_phase(stage_pkg::PH_DT1, 6);
    chk_bit(out0, 1'b0, "out0 released");
    wait_phase(stage_pkg::PH_OT1, 6);
    repeat (25) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT1);
    chk_bit(out1, 1'b0, "out1 off while waiting");
    a_act = 1'b0;
    wait_phase(stage_pkg::PH_DT0, 6);
    wait_phase(stage_pkg::PH_OT0, 6);
    repeat (3) @(negedge ref_clk);
    a_act = 1'b1;
    wait_phase(stage_pkg::PH_DT1, 6);
    a_act = 1'b0;
    wait_phase(stage_pkg::PH_OT1, 6);
    n = 0;
    while (phase === stage_pkg::PH_OT1 && out1 === 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(n == 20, 1'b1, "side one completed");
  endtask

  // Run opposite while input B stays active: ignored on side zero, then loops.
  task automatic s_mode3_b();
    idle();
    mode_b = stage_pkg::MODE_RUN_OPPOSITE;
    wait_phase(stage_pkg::PH_OT0, 60);
    repeat (2) @(negedge ref_clk);
    b_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT0);
    chk_bit(out0, 1'b1, "out0 kept");
    wait_phase(stage_pkg::PH_DT0, 30);
    wait_phase(stage_pkg::PH_OT0, 10);
    wait_phase(stage_pkg::PH_DT1, 30);
    wait_phase(stage_pkg::PH_DT0, 6);
    b_act = 1'b0;
    wait_phase(stage_pkg::PH_OT1, 60);
    chk_bit(out1, 1'b1, "out1 back");
  endtask

  // Blanking on input A with a low active level: timing runs on.
  task automatic s_mode4();
    idle();
    pol = 2'b00;
    mode_a = stage_pkg::MODE_BLANK;
    repeat (5) @(negedge ref_clk);
    wait_phase(stage_pkg::PH_OT0, 60);
    a_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_bit(out0, 1'b0, "out0 blanked");
    chk_phase(phase, stage_pkg::PH_OT0);
    wait_phase(stage_pkg::PH_OT1, 30);
    chk_bit(out1, 1'b0, "out1 blanked");
    a_act = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_bit(out1, 1'b1, "out1 after low level gone");
    pol = 2'b11;
  endtask

  // Halt on input B raised in dead-time zero, cleared only by a fresh run bit.
  task automatic s_mode7_b();
    logic [1:0] held;
    idle();
    mode_b = stage_pkg::MODE_HALT;
    wait_phase(stage_pkg::PH_DT0, 60);
    b_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_bit(halted, 1'b1, "halted");
    chk_bit(out0 | out1, 1'b0, "outputs off when halted");
    held = phase;
    b_act = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk_bit(halted, 1'b1, "halt kept");
    chk_bit(phase === held, 1'b1, "timing frozen");
    run = 1'b0;
    @(negedge ref_clk);
    run = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_bit(halted, 1'b0, "halt cleared");
  endtask

  // Edge retrigger on A: side one edge ignored, on-time zero edge cuts the cycle.
  task automatic s_mode8_a();
    idle();
    mode_a = stage_pkg::MODE_EDGE;
    wait_phase(stage_pkg::PH_OT1, 60);
    a_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT1);
    a_act = 1'b0;
    wait_phase(stage_pkg::PH_OT0, 40);
    repeat (3) @(negedge ref_clk);
    a_act = 1'b1;
    wait_phase(stage_pkg::PH_DT1, 6);
    a_act = 1'b0;
    one_ramp = 1'b1;
    wait_phase(stage_pkg::PH_OT0, 60);
    repeat (3) @(negedge ref_clk);
    a_act = 1'b1;
    wait_phase(stage_pkg::PH_DT0, 6);
    a_act = 1'b0;
    one_ramp = 1'b0;
  endtask

  // Fixed frequency retrigger on A: output ends, phase keeps running.
  task automatic s_mode9_a();
    idle();
    mode_a = stage_pkg::MODE_FIXED_EDGE;
    wait_phase(stage_pkg::PH_OT0, 60);
    repeat (3) @(negedge ref_clk);
    a_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_bit(out0, 1'b0, "out0 ended");
    chk_phase(phase, stage_pkg::PH_OT0);
  endtask

  // Hold-off on B: output one stays off while B is active, frequency unchanged.
  task automatic s_mode14_b();
    idle();
    mode_b = stage_pkg::MODE_HOLD_OFF;
    wait_phase(stage_pkg::PH_OT1, 60);
    repeat (2) @(negedge ref_clk);
    b_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_bit(out1, 1'b0, "out1 held off");
    chk_phase(phase, stage_pkg::PH_OT1);
    repeat (5) @(negedge ref_clk);
    chk_bit(out1, 1'b0, "out1 still off");
    b_act = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_bit(out1, 1'b1, "out1 back");
  endtask

  // Codes without a reaction leave the on-time zero output untouched.
  task automatic s_reserved();
    logic [3:0] codes [9];
    codes = '{4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'h0};
    foreach (codes[i]) begin
      idle();
      mode_a = codes[i];
      wait_phase(stage_pkg::PH_DT0, 60);
      wait_phase(stage_pkg::PH_OT0, 6);
      a_act = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk_bit(out0, 1'b1, "out0 with inert code");
      chk_phase(phase, stage_pkg::PH_OT0);
    end
  endtask

  // Stop and wait on input B: ignored on side zero, runs side zero, then waits.
  task automatic s_mode2_b();
    idle();
    mode_b = stage_pkg::MODE_STOP_WAIT;
    wait_phase(stage_pkg::PH_DT0, 60);
    wait_phase(stage_pkg::PH_OT0, 6);
    b_act = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT0);
    chk_bit(out0, 1'b1, "out0 kept");
    wait_phase(stage_pkg::PH_DT1, 30);
    wait_phase(stage_pkg::PH_DT0, 6);
    chk_bit(out1, 1'b0, "out1 released");
    wait_phase(stage_pkg::PH_OT0, 6);
    repeat (25) @(negedge ref_clk);
    chk_phase(phase, stage_pkg::PH_OT0);
    chk_bit(out0, 1'b0, "out0 off while waiting");
    b_act = 1'b0;
    wait_phase(stage_pkg::PH_DT1, 6);
  endtask

  // Run opposite while input A stays active: dead-time zero leads back to side one.
  task automatic s_mode3_a();
    idle();
    mode_a = stage_pkg::MODE_RUN_OPPOSITE;
    wait_phase(stage_pkg::PH_DT0, 60);
    wait_phase(stage_pkg::PH_OT0, 6);
    repeat (2) @(negedge ref_clk);
    a_act = 1'b1;
    wait_phase(stage_pkg::PH_DT1, 6);
    chk_bit(out0, 1'b0, "out0 released");
    wait_phase(stage_pkg::PH_OT1, 6);
    wait_phase(stage_pkg::PH_DT0, 30);
    wait_phase(stage_pkg::PH_DT1, 6);
    a_act = 1'b0;
    wait_phase(stage_pkg::PH_OT0, 60);
    chk_bit(out0, 1'b1, "out0 back");
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // Reset, then the scenarios in turn.
  initial begin
    errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    run = 1'b1;
    one_ramp = 1'b0;
    a_act = 1'b0;
    b_act = 1'b0;
    pol = 2'b11;
    mode_a = stage_pkg::MODE_NONE;
    mode_b = stage_pkg::MODE_NONE;
    dt0 = 12'h002;
    ot0 = 12'h014;
    dt1 = 12'h002;
    ot1 = 12'h014;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    s_normal();
    s_mode2_a();
    s_mode3_b();
    s_mode4();
    s_mode7_b();
    s_mode8_a();
    s_mode9_a();
    s_mode14_b();
    s_reserved();
    s_mode2_b();
    s_mode3_a();
    results();
  end
endmodule

`default_nettype wire
